// File: src/omu_pkg.sv
package omu_pkg;
	// ==========================================
	// Sizes
	localparam int OMU_PIXW = 8;
	localparam int OMU_COLW = 10;
	localparam int OMU_DEPTH = 1024;

	// ==========================================
	// Blend weights in eighths
	localparam logic [3:0] OMU_W_NONE = 4'h0;
	localparam logic [3:0] OMU_W_LO = 4'h1;
	localparam logic [3:0] OMU_W_QTR = 4'h2;
	localparam logic [3:0] OMU_W_HALF = 4'h4;
	localparam logic [3:0] OMU_W_3Q = 4'h6;
	localparam logic [3:0] OMU_W_HI = 4'h7;
	localparam logic [3:0] OMU_W_FULL = 4'h8;

	// ==========================================
	// Register map and fields
	localparam logic [7:0] OMU_REG_CTRL = 8'h00;
	localparam logic [7:0] OMU_REG_LINES = 8'h04;
	localparam logic [7:0] OMU_REG_STATUS = 8'h08;
	localparam int OMU_CTRL_METHOD = 0;
	localparam int OMU_CTRL_FMT = 2;
	localparam int OMU_CTRL_UP = 4;
	localparam int OMU_CTRL_FF = 5;
	localparam logic [5:0] OMU_CTRL_RST = 6'h00;
	localparam logic [9:0] OMU_LINES_RST = 10'h20d;
	localparam logic [1:0] OMU_RESP_OKAY = 2'h0;
	localparam logic [1:0] OMU_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OMU_MIX_OFF, OMU_MIX_EXT, OMU_MIX_INT, OMU_MIX_HARD
	} omu_method_t;
	typedef enum logic [1:0] {
		OMU_FMT_YC16, OMU_FMT_YC8, OMU_FMT_656, OMU_FMT_RGB24
	} omu_format_t;

	// ==========================================
	// Palette, packed as Y, Cb, Cr
	localparam logic [23:0] OMU_PAL_BLUE = 24'h23d472;
	localparam logic [23:0] OMU_PAL_RED = 24'h515af0;
	localparam logic [23:0] OMU_PAL_MAGENTA = 24'h6acade;
	localparam logic [23:0] OMU_PAL_GREEN = 24'h913622;
	localparam logic [23:0] OMU_PAL_CYAN = 24'haaa610;
	localparam logic [23:0] OMU_PAL_YELLOW = 24'hd21092;
	localparam logic [23:0] OMU_PAL_WHITE = 24'heb8080;

	function automatic logic [23:0] omu_colour(input logic [2:0] sel,
		input logic [23:0] pix);
		case (sel)
			3'h1: return OMU_PAL_BLUE;
			3'h2: return OMU_PAL_RED;
			3'h3: return OMU_PAL_MAGENTA;
			3'h4: return OMU_PAL_GREEN;
			3'h5: return OMU_PAL_CYAN;
			3'h6: return OMU_PAL_YELLOW;
			3'h7: return OMU_PAL_WHITE;
			default: return pix;
		endcase
	endfunction

	function automatic logic [7:0] omu_avg(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b} + 9'h001;
		return s[8:1];
	endfunction
endpackage

// File: src/omu_tap3.sv
`timescale 1ns/10ps
module omu_tap3 (
	// Samples.
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [7:0] c,
	// Weights in eighths, summing to eight.
	input wire logic [3:0] wa,
	input wire logic [3:0] wb,
	input wire logic [3:0] wc,
	// Rounded result.
	output logic [7:0] y
);
	logic [11:0] sum;

	always_comb begin
		sum = 12'(wa) * 12'(a) + 12'(wb) * 12'(b) + 12'(wc) * 12'(c)
			+ 12'h004;
		y = sum[10:3];
	end
endmodule

// File: src/omu_linebuf.sv
`timescale 1ns/10ps
module omu_linebuf (
	// Clock.
	input wire logic ref_clk,
	// Read port, one cycle latency.
	input wire logic [9:0] rdAddr,
	output logic [23:0] rdData,
	// Write port.
	input wire logic wrEn,
	input wire logic [9:0] wrAddr,
	input wire logic [23:0] wrData
);
	logic [23:0] mem [0:omu_pkg::OMU_DEPTH-1];

	always_ff @(posedge ref_clk) begin
		rdData <= mem[rdAddr];
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end
endmodule

// File: src/omu_mixer_top.sv
`timescale 1ns/10ps
module omu_mixer_top (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// AXI4-Lite write.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read.
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Video in.
	input wire logic pixValid,
	input wire logic [7:0] pixY,
	input wire logic [7:0] pixCb,
	input wire logic [7:0] pixCr,
	input wire logic pixLineStart,
	input wire logic pixFrameStart,
	input wire logic [2:0] overlaySelect,
	input wire logic blendLevelHi,
	input wire logic blendLevelLo,
	// Video out, 4:4:4.
	output logic outValid,
	output logic [7:0] outY,
	output logic [7:0] outCb,
	output logic [7:0] outCr,
	output logic outLineStart,
	output logic outField
);
	// ==========================================
	// Register slave
	logic [5:0] ctrl;
	logic [9:0] frameLines;
	logic awHeld;
	logic wHeld;
	logic [7:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic commit;
	logic field;
	logic [9:0] lineIdx;
	logic upAct;
	logic ffAct;
	omu_pkg::omu_format_t fmt;
	omu_pkg::omu_method_t ovlMethod;

	assign commit = awHeld && wHeld && !s_axi_bvalid;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrAddr <= 8'h00;
			wrData <= 32'h0;
			wrStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= omu_pkg::OMU_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wrAddr <= s_axi_awaddr;
				awHeld <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
				wHeld <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (commit) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wrAddr == omu_pkg::OMU_REG_CTRL ||
					wrAddr == omu_pkg::OMU_REG_LINES ||
					wrAddr == omu_pkg::OMU_REG_STATUS) begin
					s_axi_bresp <= omu_pkg::OMU_RESP_OKAY;
				end else begin
					s_axi_bresp <= omu_pkg::OMU_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Status is read-only; a write to it is accepted and dropped.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctrl <= omu_pkg::OMU_CTRL_RST;
			frameLines <= omu_pkg::OMU_LINES_RST;
		end else if (commit) begin
			if (wrAddr == omu_pkg::OMU_REG_CTRL && wrStrb[0]) begin
				ctrl <= wrData[5:0];
			end
			if (wrAddr == omu_pkg::OMU_REG_LINES) begin
				if (wrStrb[0]) begin
					frameLines[7:0] <= wrData[7:0];
				end
				if (wrStrb[1]) begin
					frameLines[9:8] <= wrData[9:8];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= omu_pkg::OMU_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= omu_pkg::OMU_RESP_OKAY;
			case (s_axi_araddr)
				omu_pkg::OMU_REG_CTRL: s_axi_rdata <= {26'h0, ctrl};
				omu_pkg::OMU_REG_LINES: s_axi_rdata <= {22'h0, frameLines};
				omu_pkg::OMU_REG_STATUS: begin
					s_axi_rdata <= {6'h0, lineIdx, 13'h0, ffAct, upAct, field};
				end
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= omu_pkg::OMU_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================
	// Mode decode
	// Upscaling wins over a stray flicker request, and the filter refuses
	// the byte-serial formats, so the two paths can never run together.
	always_comb begin
		fmt = omu_pkg::omu_format_t'(ctrl[omu_pkg::OMU_CTRL_FMT +: 2]);
		upAct = ctrl[omu_pkg::OMU_CTRL_UP];
		ffAct = ctrl[omu_pkg::OMU_CTRL_FF] && !upAct &&
			fmt != omu_pkg::OMU_FMT_YC8 && fmt != omu_pkg::OMU_FMT_656;
		ovlMethod = omu_pkg::omu_method_t'(ctrl[1:0]);
		if (fmt == omu_pkg::OMU_FMT_RGB24) begin
			ovlMethod = omu_pkg::OMU_MIX_OFF;
		end
	end

	// ==========================================
	// Overlay pipeline: s1 is the next pixel, s2 the one being mixed
	logic s1Valid, s2Valid, s1Line, s2Line, s1Frame, s2Frame;
	logic [23:0] s1Pix, s2Pix;
	logic [2:0] s1Sel, s2Sel, prevSel;
	logic [1:0] s1Lvl, s2Lvl;
	logic shifted;

	// One pixel of lookahead lets internal mixing start its ramp early.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			{s1Valid, s2Valid, s1Line, s2Line} <= 4'h0;
			{s1Frame, s2Frame, shifted} <= 3'h0;
			{s1Pix, s2Pix} <= 48'h0;
			{s1Sel, s2Sel, prevSel} <= 9'h000;
			{s1Lvl, s2Lvl} <= 4'h0;
		end else begin
			shifted <= pixValid;
			if (pixValid) begin
				s1Valid <= 1'b1;
				s1Pix <= {pixY, pixCb, pixCr};
				s1Sel <= overlaySelect;
				s1Lvl <= {blendLevelHi, blendLevelLo};
				s1Line <= pixLineStart;
				s1Frame <= pixFrameStart;
				s2Valid <= s1Valid;
				s2Pix <= s1Pix;
				s2Sel <= s1Sel;
				s2Lvl <= s1Lvl;
				s2Line <= s1Line;
				s2Frame <= s1Frame;
				prevSel <= s2Sel;
			end
		end
	end

	logic [23:0] curC, mixFg, mixBg, mixOut;
	logic [3:0] mixW, mixWc;

	always_comb begin
		curC = omu_pkg::omu_colour(s2Sel, s2Pix);
		mixFg = curC;
		mixBg = s2Pix;
		mixW = omu_pkg::OMU_W_NONE;
		case (ovlMethod)
			omu_pkg::OMU_MIX_EXT: begin
				if (s2Sel != 3'h0) begin
					case (s2Lvl)
						2'h0: mixW = omu_pkg::OMU_W_NONE;
						2'h1: mixW = omu_pkg::OMU_W_LO;
						2'h2: mixW = omu_pkg::OMU_W_HI;
						default: mixW = omu_pkg::OMU_W_FULL;
					endcase
				end
			end
			omu_pkg::OMU_MIX_INT: begin
				// A change just behind wins over one just ahead; with
				// runs of three or more the two never meet.
				if (prevSel != s2Sel) begin
					mixBg = omu_pkg::omu_colour(prevSel, s2Pix);
					mixW = omu_pkg::OMU_W_HI;
				end else if (s1Sel != s2Sel) begin
					mixFg = omu_pkg::omu_colour(s1Sel, s2Pix);
					mixBg = curC;
					mixW = omu_pkg::OMU_W_LO;
				end else begin
					mixW = omu_pkg::OMU_W_FULL;
				end
			end
			omu_pkg::OMU_MIX_HARD: begin
				if (s2Sel != 3'h0) begin
					mixW = omu_pkg::OMU_W_FULL;
				end
			end
			default: mixW = omu_pkg::OMU_W_NONE;
		endcase
		mixWc = 4'(omu_pkg::OMU_W_FULL - mixW);
	end

	for (genvar gi = 0; gi < 3; gi++) begin : g_mix
		omu_tap3 u_tap (
			.a(mixFg[gi*8 +: 8]),
			.b(mixBg[gi*8 +: 8]),
			.c(8'h00),
			.wa(mixW),
			.wb(mixWc),
			.wc(omu_pkg::OMU_W_NONE),
			.y(mixOut[gi*8 +: 8])
		);
	end

	logic mixValid, mixLine, mixFrame;
	logic [23:0] mixPix;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			{mixValid, mixLine, mixFrame} <= 3'h0;
			mixPix <= 24'h0;
		end else begin
			mixValid <= shifted && s2Valid;
			if (shifted) begin
				mixPix <= mixOut;
				mixLine <= s2Line;
				mixFrame <= s2Frame;
			end
		end
	end

	// ==========================================
	// Flicker filter
	logic [9:0] ffCol, rdAddr, colD, idxD, curIdx;
	logic ffValid;
	logic [23:0] mixD, up1, up2, ffOut;
	logic [3:0] fw0, fw1, fw2;
	logic ffEmit, lastLine;

	always_comb begin
		rdAddr = mixLine ? 10'h000 : ffCol;
		curIdx = lineIdx;
		if (mixLine) begin
			curIdx = mixFrame ? 10'h000 : 10'(lineIdx + 10'h001);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ffCol <= 10'h000;
			lineIdx <= 10'h000;
			field <= 1'b0;
		end else if (mixValid) begin
			ffCol <= 10'(rdAddr + 10'h001);
			lineIdx <= curIdx;
			if (mixFrame) begin
				field <= !field;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ffValid <= 1'b0;
			{colD, idxD} <= 20'h0;
			mixD <= 24'h0;
		end else begin
			ffValid <= mixValid && ffAct;
			colD <= rdAddr;
			idxD <= curIdx;
			mixD <= mixPix;
		end
	end

	omu_linebuf u_buf1 (
		.ref_clk(ref_clk),
		.rdAddr(rdAddr),
		.rdData(up1),
		.wrEn(ffValid),
		.wrAddr(colD),
		.wrData(mixD)
	);

	omu_linebuf u_buf2 (
		.ref_clk(ref_clk),
		.rdAddr(rdAddr),
		.rdData(up2),
		.wrEn(ffValid),
		.wrAddr(colD),
		.wrData(up1)
	);

	// Centre line is normally the one before the incoming line, so output
	// trails the input; only lines of this field's parity are emitted.
	always_comb begin
		lastLine = idxD == 10'(frameLines - 10'h001);
		fw0 = omu_pkg::OMU_W_QTR;
		fw1 = omu_pkg::OMU_W_HALF;
		fw2 = omu_pkg::OMU_W_QTR;
		ffEmit = idxD[0] != field;
		if (idxD == 10'h000) begin
			ffEmit = 1'b0;
		end else if (lastLine && idxD[0] == field) begin
			fw0 = omu_pkg::OMU_W_NONE;
			fw1 = omu_pkg::OMU_W_QTR;
			fw2 = omu_pkg::OMU_W_3Q;
			ffEmit = 1'b1;
		end else if (idxD == 10'h001) begin
			fw0 = omu_pkg::OMU_W_NONE;
			fw1 = omu_pkg::OMU_W_3Q;
			fw2 = omu_pkg::OMU_W_QTR;
		end
	end

	for (genvar gf = 0; gf < 3; gf++) begin : g_ff
		omu_tap3 u_tap (
			.a(up2[gf*8 +: 8]),
			.b(up1[gf*8 +: 8]),
			.c(mixD[gf*8 +: 8]),
			.wa(fw0),
			.wb(fw1),
			.wc(fw2),
			.y(ffOut[gf*8 +: 8])
		);
	end

	// ==========================================
	// Output selection and 2X horizontal upscaler
	logic [23:0] upPrev, upPend, upAvg;
	logic upPendValid;

	always_comb begin
		for (int k = 0; k < 3; k++) begin
			upAvg[k*8 +: 8] = omu_pkg::omu_avg(
				mixLine ? mixPix[k*8 +: 8] : upPrev[k*8 +: 8],
				mixPix[k*8 +: 8]);
		end
	end

	// Each half-rate sample leaves as an interpolated sample then itself;
	// lines and fields pass one to one, so the same frame serves both.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			outValid <= 1'b0;
			{outY, outCb, outCr} <= 24'h0;
			outLineStart <= 1'b0;
			outField <= 1'b0;
			upPrev <= 24'h0;
			upPend <= 24'h0;
			upPendValid <= 1'b0;
		end else begin
			outValid <= 1'b0;
			outLineStart <= 1'b0;
			outField <= field;
			upPendValid <= 1'b0;
			if (upAct) begin
				if (mixValid) begin
					outValid <= 1'b1;
					{outY, outCb, outCr} <= upAvg;
					outLineStart <= mixLine;
					upPrev <= mixPix;
					upPend <= mixPix;
					upPendValid <= 1'b1;
				end else if (upPendValid) begin
					outValid <= 1'b1;
					{outY, outCb, outCr} <= upPend;
				end
			end else if (ffAct) begin
				if (ffValid && ffEmit) begin
					outValid <= 1'b1;
					{outY, outCb, outCr} <= ffOut;
					outLineStart <= colD == 10'h000;
				end
			end else if (mixValid) begin
				outValid <= 1'b1;
				{outY, outCb, outCr} <= mixPix;
				outLineStart <= mixLine;
			end
		end
	end

	// ==========================================
	// Checks
	sequence sqUpIn;
		upAct && mixValid;
	endsequence
	sequence sqRise;
		shifted && ovlMethod == omu_pkg::OMU_MIX_INT && prevSel == 3'h0
			&& s2Sel == 3'h0 && s1Sel != 3'h0;
	endsequence

	AST_EXT_FULL: assert property (@(posedge ref_clk) disable iff (!rstn)
		shifted && s2Valid && ovlMethod == omu_pkg::OMU_MIX_EXT &&
		s2Sel != 3'h0 && s2Lvl == 2'h3 |=> mixValid && mixPix == $past(curC))
		else $error("external full level did not give palette colour");
	AST_EXT_IGNORE: assert property (@(posedge ref_clk) disable iff (!rstn)
		shifted && ovlMethod == omu_pkg::OMU_MIX_EXT && s2Sel == 3'h0
		|=> mixPix == $past(s2Pix))
		else $error("external mode altered a pixel with select zero");
	AST_INT_RISE: assert property (@(posedge ref_clk) disable iff (!rstn)
		sqRise |-> mixW == omu_pkg::OMU_W_LO && mixFg == omu_pkg::omu_colour(s1Sel, s2Pix))
		else $error("early ramp step is not one eighth of new overlay");
	AST_INT_FALL: assert property (@(posedge ref_clk) disable iff (!rstn)
		ovlMethod == omu_pkg::OMU_MIX_INT && prevSel != 3'h0 && s2Sel == 3'h0
		|-> mixW == omu_pkg::OMU_W_HI && mixFg == s2Pix)
		else $error("overlay to pixel step is not seven eighths pixel");
	AST_INT_SWAP: assert property (@(posedge ref_clk) disable iff (!rstn)
		ovlMethod == omu_pkg::OMU_MIX_INT && prevSel != 3'h0 && s2Sel != 3'h0
		&& prevSel != s2Sel |-> mixW == omu_pkg::OMU_W_HI)
		else $error("aligned overlay swap is not seven eighths new");
	AST_HARD: assert property (@(posedge ref_clk) disable iff (!rstn)
		shifted && ovlMethod == omu_pkg::OMU_MIX_HARD && s2Sel != 3'h0
		|=> mixPix == $past(curC))
		else $error("hard switch did not show palette colour");
	AST_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
		shifted && ovlMethod == omu_pkg::OMU_MIX_OFF |=> mixPix == $past(s2Pix))
		else $error("disabled overlay changed the pixel");
	AST_EXCL: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(upAct && ffAct))
		else $error("upscaler and flicker filter active together");
	AST_UP_PAIR: assert property (@(posedge ref_clk) disable iff (!rstn)
		sqUpIn |=> outValid ##1 outValid)
		else $error("upscaler did not emit two samples per input");
	AST_FF_TOP: assert property (@(posedge ref_clk) disable iff (!rstn)
		ffValid && idxD == 10'h001 && !lastLine
		|-> fw0 == omu_pkg::OMU_W_NONE && fw1 == omu_pkg::OMU_W_3Q)
		else $error("first field line lacks compensated weights");
endmodule

// File: verif/omu_video_src.sv
`timescale 1ns/10ps
module omu_video_src (
	// Clock.
	input wire logic ref_clk,
	// Stream to the mixer.
	output logic pixValid,
	output logic [7:0] pixY,
	output logic [7:0] pixCb,
	output logic [7:0] pixCr,
	output logic pixLineStart,
	output logic pixFrameStart,
	output logic [2:0] overlaySelect,
	output logic blendLevelHi,
	output logic blendLevelLo
);
	initial begin
		pixValid = 1'b0;
		{pixY, pixCb, pixCr} = 24'h000000;
		{pixLineStart, pixFrameStart} = 2'h0;
		overlaySelect = 3'h0;
		{blendLevelHi, blendLevelLo} = 2'h0;
	end

	// ==========================================
	// Stream task
	// Idle cycles carry inverted values, so sampling without pixValid shows.
	task automatic send(input int n, input int gap, input int minRun,
		input int lineLen);
		int run;
		logic [2:0] sel;
		run = 0;
		sel = 3'h0;
		for (int i = 0; i < n; i++) begin
			if (run >= minRun && $urandom_range(1) == 0) begin
				sel = 3'($urandom_range(7));
				run = 0;
			end
			run++;
			@(posedge ref_clk);
			pixValid <= 1'b1;
			{pixY, pixCb, pixCr} <= 24'($urandom);
			pixLineStart <= (i % lineLen == 0);
			pixFrameStart <= (i == 0);
			overlaySelect <= sel;
			{blendLevelHi, blendLevelLo} <= 2'($urandom);
			repeat (gap) begin
				@(posedge ref_clk);
				pixValid <= 1'b0;
				{pixY, pixCb, pixCr} <= ~{pixY, pixCb, pixCr};
				overlaySelect <= ~overlaySelect;
			end
		end
		@(posedge ref_clk);
		pixValid <= 1'b0;
	endtask
endmodule

// File: verif/overlay_mix_upscale_flicker_test.sv
`timescale 1ns/10ps
module overlay_mix_upscale_flicker_test;
	logic ref_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, pixValid, pixLineStart;
	logic pixFrameStart, blendLevelHi, blendLevelLo, outValid;
	logic outLineStart, outField;
	logic [7:0] awaddr, araddr, pixY, pixCb, pixCr, outY, outCb, outCr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [2:0] overlaySelect;
	logic [28:0] inQ[$];
	logic [23:0] outQ[$];
	int nFail = 0;
	int totalChecks = 0;
	int nLs = 0;
	int seed;

	omu_mixer_top uut (.ref_clk(ref_clk), .rstn(rstn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .pixValid(pixValid),
		.pixY(pixY), .pixCb(pixCb), .pixCr(pixCr),
		.pixLineStart(pixLineStart), .pixFrameStart(pixFrameStart),
		.overlaySelect(overlaySelect), .blendLevelHi(blendLevelHi),
		.blendLevelLo(blendLevelLo), .outValid(outValid), .outY(outY),
		.outCb(outCb), .outCr(outCr), .outLineStart(outLineStart),
		.outField(outField));
	omu_video_src src (.ref_clk(ref_clk), .pixValid(pixValid),
		.pixY(pixY), .pixCb(pixCb), .pixCr(pixCr),
		.pixLineStart(pixLineStart), .pixFrameStart(pixFrameStart),
		.overlaySelect(overlaySelect), .blendLevelHi(blendLevelHi),
		.blendLevelLo(blendLevelLo));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (rstn && pixValid) begin
			inQ.push_back({overlaySelect, blendLevelHi, blendLevelLo, pixY,
				pixCb, pixCr});
		end
		if (rstn && outValid) begin
			outQ.push_back({outY, outCb, outCr});
		end
		if (rstn && outValid && outLineStart) begin
			nLs++;
		end
	end

	// ==========================================
	// Expectations
	function automatic logic [23:0] pal(input logic [2:0] s);
		case (s)
			3'h1: return omu_pkg::OMU_PAL_BLUE;
			3'h2: return omu_pkg::OMU_PAL_RED;
			3'h3: return omu_pkg::OMU_PAL_MAGENTA;
			3'h4: return omu_pkg::OMU_PAL_GREEN;
			3'h5: return omu_pkg::OMU_PAL_CYAN;
			3'h6: return omu_pkg::OMU_PAL_YELLOW;
			default: return omu_pkg::OMU_PAL_WHITE;
		endcase
	endfunction

	function automatic logic [23:0] mix(input int w, input logic [23:0] f,
		input logic [23:0] b);
		logic [23:0] r;
		int s;
		for (int k = 0; k < 24; k += 8) begin
			s = (w * f[k+:8] + (8 - w) * b[k+:8] + 4) >> 3;
			r[k+:8] = 8'(s);
		end
		return r;
	endfunction

	function automatic logic [23:0] tap3(input int wa, input int wb,
		input int wc, input logic [23:0] a, input logic [23:0] b,
		input logic [23:0] c);
		logic [23:0] r;
		for (int k = 0; k < 24; k += 8) begin
			r[k+:8] = 8'((wa * a[k+:8] + wb * b[k+:8] + wc * c[k+:8] + 4) >> 3);
		end
		return r;
	endfunction

	function automatic logic [23:0] avgUp(input logic [23:0] a,
		input logic [23:0] b);
		logic [23:0] r;
		for (int k = 0; k < 24; k += 8) begin
			r[k+:8] = 8'((a[k+:8] + b[k+:8] + 1) >> 1);
		end
		return r;
	endfunction

	function automatic logic [23:0] expMix(input int m, input int i);
		logic [2:0] p, c, n;
		logic [23:0] px;
		int lw[4] = '{0, 1, 7, 8};
		c = inQ[i][28:26];
		px = inQ[i][23:0];
		p = (i > 0) ? inQ[i-1][28:26] : 3'h0;
		n = inQ[i+1][28:26];
		if (m == 0 || (c == 3'h0 && (m != 2 || (p == c && n == c)))) begin
			return px;
		end
		if (m == 1) begin
			return mix(lw[inQ[i][25:24]], pal(c), px);
		end
		if (m == 3 || (p == c && n == c)) begin
			return pal(c);
		end
		// A change behind this pixel takes precedence over one ahead.
		if (c != p) begin
			if (p == 3'h0) return mix(7, pal(c), px);
			if (c == 3'h0) return mix(1, pal(p), px);
			return mix(7, pal(c), pal(p));
		end
		if (c == 3'h0) return mix(1, pal(n), px);
		if (n == 3'h0) return mix(7, pal(c), px);
		return mix(1, pal(n), pal(c));
	endfunction

	// ==========================================
	// Bus and check tasks
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			nFail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic axWrite(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		{awaddr, wdata, wstrb} <= {a, d, 4'hf};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axRead(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask

	task automatic resetDut();
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#100000;
		nFail++;
		complete_run();
	end

	// ==========================================
	// Scenarios
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int m, n, ne;
		logic [5:0] ctl[7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0f, 6'h10,
			6'h20};
		int mth[7] = '{0, 1, 2, 3, 0, 4, 5};
		logic [5:0] sc[4] = '{6'h20, 6'h30, 6'h24, 6'h28};
		logic [1:0] se[4] = '{2'h2, 2'h1, 2'h0, 2'h0};
		rstn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		seed = $urandom(32'h9630ecc3);
		resetDut();
		axRead(omu_pkg::OMU_REG_CTRL, d, r);
		chk("ctrl reset", 32'h0, d);
		axRead(omu_pkg::OMU_REG_LINES, d, r);
		chk("lines reset", 32'h20d, d);
		axRead(8'h0c, d, r);
		chk("unmapped resp", 32'(omu_pkg::OMU_RESP_SLVERR), 32'(r));
		chk("unmapped data", 32'h0, d);
		axWrite(omu_pkg::OMU_REG_STATUS, 32'h6, r);
		chk("status write", 32'(omu_pkg::OMU_RESP_OKAY), 32'(r));
		for (int k = 0; k < 4; k++) begin
			axWrite(omu_pkg::OMU_REG_CTRL, 32'(sc[k]), r);
			axRead(omu_pkg::OMU_REG_STATUS, d, r);
			chk("status active", 32'(se[k]), 32'(d[2:1]));
		end
		// Internal mixing is exercised with the 16-bit format only.
		for (int k = 0; k < 7; k++) begin
			m = mth[k];
			n = (m == 4) ? 30 : (m == 5) ? 16 : 60;
			// A four-line frame of four pixels; the field keeps odd centres.
			ne = (m == 4) ? 2 * (n - 1) : (m == 5) ? 7 : n - 1;
			resetDut();
			if (m == 5) begin
				axWrite(omu_pkg::OMU_REG_LINES, 32'h4, r);
			end
			axWrite(omu_pkg::OMU_REG_CTRL, 32'(ctl[k]), r);
			axRead(omu_pkg::OMU_REG_CTRL, d, r);
			chk("ctrl readback", 32'(ctl[k]), d);
			inQ.delete();
			outQ.delete();
			nLs = 0;
			src.send(n, (m == 4) ? 1 : 0, (m == 2) ? 3 : 1,
				(m == 5) ? 4 : n);
			for (int t = 0; t < 300 && outQ.size() < ne; t++) begin
				@(posedge ref_clk);
			end
			repeat (8) @(posedge ref_clk);
			chk("out count", 32'(ne), 32'(outQ.size()));
			chk("line starts", (m == 5) ? 32'h2 : 32'h1, 32'(nLs));
			chk("field", 32'h1, 32'(outField));
			for (int i = 0; i < ne && i < outQ.size(); i++) begin
				if (m == 5) begin
					d = (i < 4) ? 32'(tap3(2, 4, 2, inQ[i][23:0],
						inQ[4+i][23:0], inQ[8+i][23:0])) :
						32'(tap3(0, 2, 6, inQ[i-4][23:0],
						inQ[i+4][23:0], inQ[i+8][23:0]));
					chk("filtered", d, 32'(outQ[i]));
				end else if (m == 4) begin
					// Each sample leaves as the midpoint to its left
					// neighbour, then itself; the first repeats itself.
					if (i % 2 == 1 || i == 0) begin
						d = 32'(inQ[i/2][23:0]);
					end else begin
						d = 32'(avgUp(inQ[i/2-1][23:0], inQ[i/2][23:0]));
					end
					chk("upscaled", d, 32'(outQ[i]));
				end else begin
					chk("mixed", 32'(expMix(m, i)), 32'(outQ[i]));
				end
			end
		end
		complete_run();
	end
endmodule
